/* File: common/uis_pkg.sv */
// constants, types and register map of the modem status and interrupt block
package uis_pkg;
   // register addresses on the 3-bit host bus
   localparam logic [2:0] ADDR_IER = 3'h1;
   localparam logic [2:0] ADDR_IIR = 3'h2; // read: ident, key open: feature
   localparam logic [2:0] ADDR_MCR = 3'h4;
   localparam logic [2:0] ADDR_MSR = 3'h6;
   // line control value that opens the enhanced feature register
   localparam logic [7:0] EFR_KEY = 8'hBF;
   localparam int LCR_DLAB = 7;
   // reset values
   localparam logic [7:0] IER_RST = 8'h00;
   localparam logic [7:0] EFR_RST = 8'h00;
   localparam logic [7:0] MCR_RST = 8'h00;
   // interrupt enable mask fields
   localparam int IER_RHR = 0;
   localparam int IER_THR = 1;
   localparam int IER_LSR = 2;
   localparam int IER_MSR = 3;
   localparam int IER_SLEEP = 4;
   localparam int IER_XOFF = 5;
   localparam int IER_RTS = 6;
   localparam int IER_CTS = 7;
   localparam logic [7:0] IER_HI_MASK = 8'hF0;
   // enhanced feature control fields
   localparam int EFR_ENH = 4;
   localparam int EFR_SPEC = 5;
   localparam int EFR_ARTS = 6;
   localparam int EFR_ACTS = 7;
   // modem line control fields
   localparam int MCR_DTR = 0;
   localparam int MCR_RTS = 1;
   localparam int MCR_OUT2 = 2;
   localparam int MCR_IRQEN = 3;
   localparam int MCR_LOOP = 4;
   localparam int MCR_THRESH = 6;
   localparam logic [7:0] MCR_HI_MASK = 8'hE0;
   // threshold nibble counts in steps of four characters
   localparam int TCR_STEP_SH = 2;
   // identification codes, bits 5..0
   localparam logic [5:0] ID_NONE = 6'h01;
   localparam logic [5:0] ID_LSR = 6'h06;
   localparam logic [5:0] ID_TMO = 6'h0C;
   localparam logic [5:0] ID_RHR = 6'h04;
   localparam logic [5:0] ID_THR = 6'h02;
   localparam logic [5:0] ID_MDM = 6'h00;
   localparam logic [5:0] ID_XOFF = 6'h10;
   localparam logic [5:0] ID_FLOW = 6'h20;
   // active-high modem line state, bit order matches status bits 7..4
   typedef struct packed {
      logic cd;
      logic ri;
      logic dsr;
      logic cts;
   } uis_modem_t;
   // one host bus cycle
   typedef struct packed {
      logic rd;
      logic wr;
      logic [2:0] addr;
      logic [7:0] wdata;
   } uis_bus_t;
   typedef enum logic [2:0] {
      SRC_NONE, SRC_LSR, SRC_TMO, SRC_RHR, SRC_THR, SRC_MDM, SRC_XOFF,
      SRC_FLOW
   } uis_src_t;
endpackage

/* File: design/uis_top.sv */
// modem status, interrupt priority and enhanced flow control of one channel
`timescale 1ns/1ps
module uis_top
   import uis_pkg::*;
#(
   parameter int LEVEL_W = 7
) (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire uis_bus_t bus_in,
   input wire logic [7:0] lcr_in,
   input wire uis_modem_t modem_n_in,
   input wire logic fifo_enable_in,
   input wire logic rx_data_avail_in,
   input wire logic rx_timeout_in,
   input wire logic rx_line_err_in,
   input wire logic tx_holding_empty_in,
   input wire logic tx_fifo_write_in,
   input wire logic rx_char_valid_in,
   input wire logic [7:0] rx_char_in,
   input wire logic [7:0] xoff2_char_in,
   input wire logic xoff_rcvd_in,
   input wire logic [LEVEL_W-1:0] rx_level_in,
   input wire logic [7:0] flow_threshold_levels_in,
   output logic [7:0] rd_data_out,
   output logic irq_out,
   output logic irq_oe_out,
   output logic rts_n_out,
   output logic dtr_n_out,
   output logic tx_halt_out,
   output logic [3:0] sw_flow_mode_out,
   output logic sleep_en_out,
   output logic enh_en_out,
   output logic loopback_out,
   output logic [7:0] modem_line_control_out
);
   // refuse fill widths the threshold logic cannot serve
   if (LEVEL_W < 6 || LEVEL_W > 16) begin : g_level_chk
      $error("uis_top: LEVEL_W must be 6..16");
   end

   // writes the bits of mask only when allowed, others always
   function automatic logic [7:0] gated_write(input logic [7:0] old_v,
      input logic [7:0] new_v, input logic [7:0] mask, input logic allow);
      logic [7:0] keep;
      keep = allow ? 8'h00 : mask;
      return (old_v & keep) | (new_v & ~keep);
   endfunction

   logic [7:0] ier_q, ier_d, efr_q, efr_d, mcr_q, mcr_d, rd_q, rd_d;
   uis_modem_t line_q, line_act;
   logic [3:0] delta_q, delta_d, edges;
   logic thr_arm_q, thr_arm_d, thr_flag_q, thr_flag_d;
   logic xoff_q, xoff_d, flow_q, flow_d, rts_halt_q, rts_halt_d;
   logic irq_q, oe_q, rts_n_q, rts_n_d, dtr_n_q, halt_q;
   logic slp_q;

   // bus decode
   wire logic key_open = (lcr_in == EFR_KEY);
   wire logic ier_sel = (bus_in.addr == ADDR_IER) && !lcr_in[LCR_DLAB];
   wire logic id_sel = (bus_in.addr == ADDR_IIR) && !key_open;
   wire logic efr_sel = (bus_in.addr == ADDR_IIR) && key_open;
   wire logic mcr_sel = (bus_in.addr == ADDR_MCR);
   wire logic msr_sel = (bus_in.addr == ADDR_MSR) && !key_open
      && !(efr_q[EFR_ENH] && mcr_q[MCR_THRESH]);
   wire logic ier_wr = bus_in.wr && ier_sel;
   wire logic efr_wr = bus_in.wr && efr_sel;
   wire logic mcr_wr = bus_in.wr && mcr_sel;
   wire logic msr_rd = bus_in.rd && msr_sel;
   wire logic id_rd = bus_in.rd && id_sel;
   wire logic enh = efr_q[EFR_ENH];
   wire logic loop = mcr_q[MCR_LOOP];

   // register writes; extended bits locked while enhanced bit clear
   assign ier_d = ier_wr ? gated_write(ier_q, bus_in.wdata, IER_HI_MASK, enh)
      : ier_q;
   assign mcr_d = mcr_wr ? gated_write(mcr_q, bus_in.wdata, MCR_HI_MASK, enh)
      : mcr_q;
   assign efr_d = efr_wr ? bus_in.wdata : efr_q;

   // effective enables, upper group off while enhanced functions off
   wire logic [7:0] ier_eff = {ier_q[7:4] & {4{enh}}, ier_q[3:0]};

   // modem line image, inverted pins or loopback control bits
   assign line_act = loop
      ? uis_modem_t'({mcr_q[MCR_IRQEN], mcr_q[MCR_OUT2], mcr_q[MCR_DTR],
         mcr_q[MCR_RTS]})
      : uis_modem_t'(~modem_n_in);
   assign edges[0] = line_act.cts ^ line_q.cts;
   assign edges[1] = line_act.dsr ^ line_q.dsr;
   assign edges[3] = line_act.cd ^ line_q.cd;
   // bell pin low-to-high is image falling; in loop control bit rising
   assign edges[2] = loop ? (line_act.ri && !line_q.ri)
      : (!line_act.ri && line_q.ri);
   // new edge wins over the clearing read
   assign delta_d = (delta_q & ~{4{msr_rd}}) | edges;

   // tx holding source: armed at reset and by fresh tx data
   wire logic thr_set = thr_arm_q && tx_holding_empty_in;
   assign thr_arm_d = tx_fifo_write_in || (thr_arm_q && !thr_set);

   // priority encode of pending enabled sources
   wire logic p_lsr_w = ier_eff[IER_LSR] && rx_line_err_in;
   wire logic p_tmo_w = ier_eff[IER_RHR] && rx_timeout_in;
   wire logic p_rhr_w = ier_eff[IER_RHR] && rx_data_avail_in;
   wire logic p_thr_w = ier_eff[IER_THR] && thr_flag_q;
   wire logic p_mdm_w = ier_eff[IER_MSR] && (|delta_q);
   wire logic p_xoff_w = ier_eff[IER_XOFF] && xoff_q;
   wire logic p_flow_w = flow_q;
   uis_src_t src;
   logic [5:0] id_code;
   always_comb begin
      if (p_lsr_w) src = SRC_LSR;
      else if (p_tmo_w) src = SRC_TMO;
      else if (p_rhr_w) src = SRC_RHR;
      else if (p_thr_w) src = SRC_THR;
      else if (p_mdm_w) src = SRC_MDM;
      else if (p_xoff_w) src = SRC_XOFF;
      else if (p_flow_w) src = SRC_FLOW;
      else src = SRC_NONE;
   end
   // codes per source, bit 0 high only when idle
   always_comb begin
      unique case (src)
         SRC_LSR: id_code = ID_LSR;
         SRC_TMO: id_code = ID_TMO;
         SRC_RHR: id_code = ID_RHR;
         SRC_THR: id_code = ID_THR;
         SRC_MDM: id_code = ID_MDM;
         SRC_XOFF: id_code = ID_XOFF;
         SRC_FLOW: id_code = ID_FLOW;
         SRC_NONE: id_code = ID_NONE;
      endcase
   end
   wire logic any_pend = (src != SRC_NONE);

   // tx flag: cleared by disabling, fresh data or ident read
   assign thr_flag_d = thr_set || (thr_flag_q && !tx_fifo_write_in
      && !(ier_wr && !bus_in.wdata[IER_THR])
      && !(id_rd && src == SRC_THR));

   // pause/special character flag, set wins over ident read
   wire logic spec_hit = efr_q[EFR_SPEC] && rx_char_valid_in
      && (rx_char_in == xoff2_char_in);
   assign xoff_d = spec_hit || xoff_rcvd_in
      || (xoff_q && !(id_rd && src == SRC_XOFF));

   // auto rts hysteresis on rx fill level
   wire logic [LEVEL_W-1:0] halt_lvl =
      LEVEL_W'(flow_threshold_levels_in[3:0]) << TCR_STEP_SH;
   wire logic [LEVEL_W-1:0] rest_lvl =
      LEVEL_W'(flow_threshold_levels_in[7:4]) << TCR_STEP_SH;
   always_comb begin
      rts_halt_d = rts_halt_q;
      if (!efr_q[EFR_ARTS]) rts_halt_d = 1'b0;
      else if (rx_level_in >= halt_lvl) rts_halt_d = 1'b1;
      else if (rx_level_in <= rest_lvl) rts_halt_d = 1'b0;
   end
   // pins idle high in loopback; auto mode overrides control bit
   assign rts_n_d = loop ? 1'b1 : (efr_q[EFR_ARTS] ? rts_halt_d
      : !mcr_q[MCR_RTS]);

   // cts or rts going inactive, counted only while enabled
   wire logic cts_rise = line_q.cts && !line_act.cts && ier_eff[IER_CTS];
   wire logic rts_rise = rts_n_d && !rts_n_q && ier_eff[IER_RTS];
   assign flow_d = cts_rise || rts_rise
      || (flow_q && !(id_rd && src == SRC_FLOW));

   // read data mux, registered
   always_comb begin
      rd_d = 8'h00;
      if (ier_sel) rd_d = ier_q;
      else if (efr_sel) rd_d = efr_q;
      else if (id_sel) rd_d = {{2{fifo_enable_in}}, id_code};
      else if (mcr_sel) rd_d = mcr_q;
      else if (msr_sel) rd_d = {line_q, delta_q};
   end

   // control registers
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ier_q <= IER_RST;
         efr_q <= EFR_RST;
         mcr_q <= MCR_RST;
      end else begin
         ier_q <= ier_d;
         efr_q <= efr_d;
         mcr_q <= mcr_d;
      end
   end

   // status and source flags
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         line_q <= '0;
         delta_q <= 4'h0;
         thr_arm_q <= 1'b1;
         thr_flag_q <= 1'b0;
         xoff_q <= 1'b0;
         flow_q <= 1'b0;
         rts_halt_q <= 1'b0;
      end else begin
         line_q <= line_act;
         delta_q <= delta_d;
         thr_arm_q <= thr_arm_d;
         thr_flag_q <= thr_flag_d;
         xoff_q <= xoff_d;
         flow_q <= flow_d;
         rts_halt_q <= rts_halt_d;
      end
   end

   // output flops
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_q <= 8'h00;
         irq_q <= 1'b0;
         oe_q <= 1'b0;
         rts_n_q <= 1'b1;
         dtr_n_q <= 1'b1;
         halt_q <= 1'b0;
         slp_q <= 1'b0;
      end else begin
         rd_q <= bus_in.rd ? rd_d : rd_q;
         irq_q <= any_pend;
         oe_q <= mcr_q[MCR_IRQEN];
         rts_n_q <= rts_n_d;
         dtr_n_q <= loop || !mcr_q[MCR_DTR];
         halt_q <= efr_q[EFR_ACTS] && !line_act.cts;
         slp_q <= ier_d[IER_SLEEP] && efr_d[EFR_ENH];
      end
   end

   assign rd_data_out = rd_q;
   assign irq_out = irq_q;
   assign irq_oe_out = oe_q;
   assign rts_n_out = rts_n_q;
   assign dtr_n_out = dtr_n_q;
   assign tx_halt_out = halt_q;
   assign sw_flow_mode_out = efr_q[3:0];
   assign sleep_en_out = slp_q;
   assign enh_en_out = efr_q[EFR_ENH];
   assign loopback_out = mcr_q[MCR_LOOP];
   assign modem_line_control_out = mcr_q;

   // checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);

   property p_msr_clear;
      msr_rd && edges == 4'h0 |=> delta_q == 4'h0;
   endproperty
   a_msr_clear: assert property (p_msr_clear)
      else $error("change bits not cleared by status read");

   property p_cts_change;
      $changed(line_q.cts) && !$past(msr_rd) |-> delta_q[0];
   endproperty
   a_cts_change: assert property (p_cts_change)
      else $error("cts change not latched");

   property p_ri_rise_only;
      !loop && $past(!loop) && $rose(line_q.ri) && !$past(delta_q[2])
         |-> !delta_q[2];
   endproperty
   a_ri_rise_only: assert property (p_ri_rise_only)
      else $error("bell change bit set on wrong edge");

   property p_msr_lines;
      msr_rd |=> rd_data_out[7:4] == $past(line_q);
   endproperty
   a_msr_lines: assert property (p_msr_lines)
      else $error("status line bits wrong");

   property p_ier_lock;
      ier_wr && !enh |=> ier_q[7:4] == $past(ier_q[7:4]);
   endproperty
   a_ier_lock: assert property (p_ier_lock)
      else $error("locked mask bits changed");

   property p_irq_follow;
      ##1 irq_out == $past(any_pend);
   endproperty
   a_irq_follow: assert property (p_irq_follow)
      else $error("interrupt output does not follow pending");

   property p_id_bit0;
      id_rd |=> rd_data_out[0] == !$past(any_pend)
         && rd_data_out[7:6] == {2{$past(fifo_enable_in)}};
   endproperty
   a_id_bit0: assert property (p_id_bit0)
      else $error("ident bit 0 or fifo mirror wrong");

   property p_thr_rearm;
      ier_wr && !bus_in.wdata[IER_THR] && !tx_fifo_write_in
         ##1 !tx_fifo_write_in [*2] |-> !thr_flag_q;
   endproperty
   a_thr_rearm: assert property (p_thr_rearm)
      else $error("tx interrupt returned without fresh data");

   property p_auto_cts;
      efr_q[EFR_ACTS] && !line_act.cts |=> tx_halt_out;
   endproperty
   a_auto_cts: assert property (p_auto_cts)
      else $error("transmit not halted on inactive cts");

   property p_irq_oe;
      ##1 irq_oe_out == $past(mcr_q[MCR_IRQEN]);
   endproperty
   a_irq_oe: assert property (p_irq_oe)
      else $error("interrupt driver enable wrong");

   property p_spec_flag;
      spec_hit |=> xoff_q;
   endproperty
   a_spec_flag: assert property (p_spec_flag)
      else $error("special character not flagged");

   c_mdm_irq: cover property (p_mdm_w && src == SRC_MDM ##1 irq_out);
   c_spec: cover property (spec_hit ##1 xoff_q);
   c_rts_auto: cover property (rts_halt_q ##[1:20] !rts_halt_q);
endmodule

/* File: dv/uis_modem_model.sv */
// modem peer that drives the active-low handshake pins
`timescale 1ns/1ps
module uis_modem_model
   import uis_pkg::*;
(
   input wire logic sys_clk_in,
   input wire uis_modem_t line_req_in,
   output uis_modem_t modem_n_out
);
   // pins move after the falling edge; cts high pauses the device
   always @(negedge sys_clk_in) begin
      modem_n_out <= ~line_req_in;
   end
endmodule

/* File: dv/uis_top_tb_top.sv */
// register level bench of the modem status and interrupt block
`timescale 1ns/1ps
module uis_top_tb_top;
   import uis_pkg::*;
   logic sys_clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   uis_bus_t bus = '0;
   uis_modem_t req = '0;
   uis_modem_t mdm_n;
   logic [7:0] lcr = 8'h00;
   logic [7:0] rxc = 8'h00;
   logic [7:0] tx_holding = 8'h12;
   logic [2:0] lv = 3'h0;
   logic [6:0] lvl = 7'h00;
   logic fen = 1'b0;
   logic txe = 1'b1;
   logic txw = 1'b0;
   logic rxv = 1'b0;
   logic [7:0] rd, modem_line_control;
   logic irq, ioe, rts_n, dtr_n, halt, slp, enh, lpb;
   logic [3:0] swf;
   logic [5:0] cd [4];
   int bad_count = 0;
   int compares = 0;

   // 25 MHz clock
   always #20 sys_clk_in = ~sys_clk_in;

   // block under test and its modem peer
   uis_top u_dut (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
      .bus_in(bus), .lcr_in(lcr), .modem_n_in(mdm_n),
      .fifo_enable_in(fen), .rx_data_avail_in(lv[0]),
      .rx_timeout_in(lv[1]), .rx_line_err_in(lv[2]),
      .tx_holding_empty_in(txe), .tx_fifo_write_in(txw),
      .rx_char_valid_in(rxv), .rx_char_in(rxc), .xoff2_char_in(8'h13),
      .xoff_rcvd_in(1'b0), .rx_level_in(lvl),
      .flow_threshold_levels_in(tx_holding), .rd_data_out(rd), .irq_out(irq),
      .irq_oe_out(ioe), .rts_n_out(rts_n), .dtr_n_out(dtr_n),
      .tx_halt_out(halt), .sw_flow_mode_out(swf), .sleep_en_out(slp),
      .enh_en_out(enh), .loopback_out(lpb), .modem_line_control_out(modem_line_control));
   uis_modem_model u_mdm (.sys_clk_in(sys_clk_in), .line_req_in(req),
      .modem_n_out(mdm_n));

   // verdict and end of run
   task finish_test;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask

   // one host write, strobe held across one rising edge
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge sys_clk_in);
      bus = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge sys_clk_in);
      bus.wr = 1'b0;
      cyc(2);
   endtask

   // one host read, data compared a cycle after the read edge
   task rdc(input logic [2:0] a, input logic [7:0] e);
      @(negedge sys_clk_in);
      bus = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(negedge sys_clk_in);
      bus.rd = 1'b0;
      @(negedge sys_clk_in);
      chk(rd, e);
   endtask

   // write the feature register behind the line control key
   task feat(input logic [7:0] d);
      lcr = EFR_KEY;
      wr(ADDR_IIR, d);
      lcr = 8'h00;
   endtask

   task mdm(input uis_modem_t v);
      req = v;
      cyc(3);
   endtask

   task pulse_txw;
      txw = 1'b1;
      cyc(1);
      txw = 1'b0;
      cyc(2);
   endtask

   // hang guard
   initial begin
      repeat (5000) @(posedge sys_clk_in);
      bad_count++;
      finish_test;
   end

   // main sequence
   initial begin
      cd = '{ID_LSR, ID_TMO, ID_RHR, ID_THR};
      cyc(4);
      arst_n_in = 1'b1;
      chk({3'h0, irq, ioe, rts_n, dtr_n, halt}, 8'h06);
      rdc(ADDR_IER, 8'h00);
      rdc(ADDR_MSR, 8'h00);
      rdc(ADDR_IIR, 8'h01);
      // extended bits locked until the feature enable is set
      wr(ADDR_IER, 8'hF0);
      rdc(ADDR_IER, 8'h00);
      wr(ADDR_MCR, 8'hE0);
      chk(modem_line_control, 8'h00);
      feat(8'h10);
      chk({7'h0, enh}, 8'h01);
      wr(ADDR_IER, 8'hF0);
      rdc(ADDR_IER, 8'hF0);
      chk({7'h0, slp}, 8'h01);
      feat(8'h1F);
      chk({4'h0, swf}, 8'h0F);
      lcr = EFR_KEY;
      rdc(ADDR_IIR, 8'h1F);
      lcr = 8'h00;
      wr(ADDR_IER, 8'h00);
      // modem line changes and bell edge
      mdm(4'h1);
      rdc(ADDR_MSR, 8'h11);
      rdc(ADDR_MSR, 8'h10);
      mdm(4'hB);
      rdc(ADDR_MSR, 8'hBA);
      mdm(4'hF);
      rdc(ADDR_MSR, 8'hF0);
      mdm(4'hB);
      rdc(ADDR_MSR, 8'hB4);
      // modem interrupt held until status read
      wr(ADDR_IER, 8'h08);
      mdm(4'h0);
      chk({7'h0, irq}, 8'h01);
      rdc(ADDR_IIR, 8'h00);
      chk({7'h0, irq}, 8'h01);
      rdc(ADDR_MSR, 8'h0B);
      cyc(2);
      chk({7'h0, irq}, 8'h00);
      rdc(ADDR_IIR, 8'h01);
      // automatic transmit halt on cts
      wr(ADDR_IER, 8'h00);
      feat(8'h90);
      chk({7'h0, halt}, 8'h01);
      mdm(4'h1);
      chk({7'h0, halt}, 8'h00);
      rdc(ADDR_MSR, 8'h11);
      // priority walk, highest source dropped each step
      fen = 1'b1;
      lv = 3'h7;
      wr(ADDR_IER, 8'h0F);
      // fresh tx data so the tx source pends at the bottom of the walk
      pulse_txw;
      for (int i = 0; i < 4; i++) begin
         rdc(ADDR_IIR, {2'b11, cd[i]});
         if (i < 3) begin
            lv[2 - i] = 1'b0;
            cyc(2);
         end
      end
      rdc(ADDR_IIR, 8'hC1);
      // tx interrupt needs fresh data after re-enable
      pulse_txw;
      rdc(ADDR_IIR, 8'hC2);
      pulse_txw;
      wr(ADDR_IER, 8'h00);
      wr(ADDR_IER, 8'h02);
      rdc(ADDR_IIR, 8'hC1);
      pulse_txw;
      rdc(ADDR_IIR, 8'hC2);
      txe = 1'b0;
      // automatic rts with rts interrupt
      feat(8'h50);
      wr(ADDR_IER, 8'h40);
      wr(ADDR_MCR, 8'h02);
      chk({7'h0, rts_n}, 8'h00);
      lvl = 7'd8;
      cyc(3);
      chk({7'h0, rts_n}, 8'h01);
      chk({7'h0, irq}, 8'h01);
      rdc(ADDR_IIR, 8'hE0);
      lvl = 7'd5;
      cyc(3);
      chk({7'h0, rts_n}, 8'h01);
      lvl = 7'd4;
      cyc(3);
      chk({7'h0, rts_n}, 8'h00);
      rdc(ADDR_IIR, 8'hC1);
      // special character match
      feat(8'h30);
      wr(ADDR_IER, 8'h20);
      rxc = 8'h13;
      rxv = 1'b1;
      cyc(1);
      rxv = 1'b0;
      cyc(2);
      rdc(ADDR_IIR, 8'hD0);
      // loopback and interrupt pin enable
      wr(ADDR_IER, 8'h00);
      wr(ADDR_MCR, 8'h1B);
      chk({4'h0, ioe, lpb, rts_n, dtr_n}, 8'h0F);
      rdc(ADDR_MSR, 8'hBA);
      rdc(ADDR_MSR, 8'hB0);
      finish_test;
   end
endmodule
